// file: design/slcd_ctrl.sv
// Control logic of the software LCD common/segment pin driver.
// Assumes a classic Wishbone master on clk_i and pin data from the same clock.
//
// Function
// - With the master enable clear every drive output sits at the ground level.
// - A per-pin enable only acts while the master enable is 1.
// - An LCD pin is driven whatever its port direction holds.
// - In frame 0 commons drive supply or one third, segments ground or two thirds.
// - In frame 1 commons drive ground or two thirds, segments supply or one third.
// - Each pin picks rail or bias level of the frame from its shared data bit.
// - The frame select is bit 7 of the main control register, 0 first frame.
// - Bits 6 to 5 of the main register pick the bias current 8.3, 16.7, 50, 100 uA.
// - Main register bits 3 to 0 hand pins 3 to 0 to the LCD when set.
// - There are six common-capable pins and twenty-four segment-capable pins.
// - Segment pins 6 to 23 are enabled by their own bits in ascending order.
// - All control registers reset to zero so LCD drive is off.
// - A role bit makes its pin a common line at 0 and a segment line at 1.
// - A segment enable bit gives the pin to the segment function when 1.
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "slcd_defs.svh"

module slcd_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`SLCD_NUM_PINS-1:0] pin_data_i,
  output logic [`SLCD_NUM_PINS*2-1:0] lcd_level_o,
  output logic [`SLCD_NUM_PINS-1:0] lcd_active_o,
  output logic [1:0] bias_current_o
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic pin_enabled(input logic [`SLCD_NUM_REGS-1:0][7:0] r,
                                       input int k);
    logic en;
    en = 1'b0;
    if (k < 4) begin
      en = r[0][k];
    end else if (k < `SLCD_NUM_COM) begin
      en = r[1][k + 2];
    end else if (k < 14) begin
      en = r[2][k - 6];
    end else if (k < 22) begin
      en = r[3][k - 14];
    end else begin
      en = r[4][k - 22];
    end
    return en;
  endfunction

  function automatic int reg_index(input logic [7:0] adr);
    int idx;
    idx = -1;
    case (adr)
      `SLCD_OFF_MAIN: idx = 0;
      `SLCD_OFF_ROLE: idx = 1;
      `SLCD_OFF_SEG_LOW: idx = 2;
      `SLCD_OFF_SEG_MID: idx = 3;
      `SLCD_OFF_SEG_HIGH: idx = 4;
      default: idx = -1;
    endcase
    return idx;
  endfunction

  // Rail side flips with role and frame; data 1 takes the rail
  function automatic slcd_pkg::slcd_level_t level_code(input logic is_com,
                                                        input logic frame,
                                                        input logic data);
    slcd_pkg::slcd_level_t lv;
    lv = slcd_pkg::SLCD_LVL_VSS;
    if (is_com ^ frame) begin
      lv = data ? slcd_pkg::SLCD_LVL_VDD : slcd_pkg::SLCD_LVL_THIRD;
    end else begin
      lv = data ? slcd_pkg::SLCD_LVL_VSS : slcd_pkg::SLCD_LVL_TWO_THIRD;
    end
    return lv;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  slcd_pkg::slcd_state_t state;
  slcd_pkg::slcd_state_t next_state;
  logic master;
  logic frame;
  logic [`SLCD_NUM_PINS-1:0] en_vec;
  logic [`SLCD_NUM_PINS-1:0] com_vec;
  logic req;
  int widx;
  int ridx;

  assign master = state.regs[0][`SLCD_MASTER_BIT];
  assign frame = state.regs[0][`SLCD_FRAME_BIT];
  assign req = wb_cyc_i && wb_stb_i;
  assign widx = reg_index(wb_adr_i);
  assign ridx = reg_index(wb_adr_i);

  // Per-pin enable and role, six common-capable pins
  genvar g;
  generate
    for (g = 0; g < `SLCD_NUM_PINS; g++) begin : gen_pin
      assign en_vec[g] = pin_enabled(state.regs, g) && master;
      if (g < `SLCD_NUM_COM) begin : gen_com
        assign com_vec[g] = ~state.regs[1][g];
      end else begin : gen_seg
        assign com_vec[g] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (ce_i) begin
      // Ack one cycle after the request; write lands on the acked edge
      next_state.ack = req && !state.ack;
      if (req && !state.ack) begin
        next_state.rdata = 32'h0000_0000;
        if (ridx >= 0) begin
          next_state.rdata[7:0] = state.regs[ridx];
        end
      end
      if (req && state.ack && wb_we_i && wb_sel_i[0] && widx >= 0) begin
        next_state.regs[widx] = wb_dat_i[7:0];
        if (widx == 4) begin
          next_state.regs[4] = wb_dat_i[7:0] & `SLCD_SEG_HIGH_MASK;
        end
      end
      for (int k = 0; k < `SLCD_NUM_PINS; k++) begin
        // Active overrides the port direction of the shared pin
        next_state.active[k] = en_vec[k];
        if (en_vec[k]) begin
          next_state.level[k] = level_code(com_vec[k], frame, pin_data_i[k]);
        end else begin
          next_state.level[k] = slcd_pkg::SLCD_LVL_VSS;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.rdata;
  assign lcd_level_o = state.level;
  assign lcd_active_o = state.active;
  assign bias_current_o = state.regs[0][`SLCD_ISEL_HI:`SLCD_ISEL_LO];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  master_off_vss_a: assert property ((ce_i && !master) |=> lcd_level_o == '0)
    else $error("level not ground with master off");

  active_gated_a: assert property (ce_i |=> lcd_active_o == $past(en_vec))
    else $error("active pins do not follow gated enables");

  active_no_dir_a: assert property ((ce_i && master && state.regs[0][0]) |=> lcd_active_o[0])
    else $error("enabled pin not owned by the driver");

  main_pins_a: assert property ((ce_i && master)
    |=> lcd_active_o[3:0] == $past(state.regs[0][3:0]))
    else $error("main register pin enables not applied");

  com_pins_a: assert property ((ce_i && master)
    |=> lcd_active_o[5:4] == $past(state.regs[1][7:6]))
    else $error("upper common pin enables not applied");

  seg_pins_a: assert property ((ce_i && master)
    |=> lcd_active_o[23:6] == $past({state.regs[4][1:0], state.regs[3], state.regs[2]}))
    else $error("segment pin enables not applied");

  seg_mid_a: assert property ((ce_i && master && state.regs[3][0])
    |=> lcd_active_o[14])
    else $error("first middle segment pin not owned");

  com_frame0_a: assert property ((ce_i && en_vec[0] && com_vec[0] && !frame
    && pin_data_i[0]) |=> lcd_level_o[1:0] == 2'h3)
    else $error("common frame 0 rail wrong");

  com_bias0_a: assert property ((ce_i && en_vec[0] && com_vec[0] && !frame
    && !pin_data_i[0]) |=> lcd_level_o[1:0] == 2'h1)
    else $error("common frame 0 bias wrong");

  com_frame1_a: assert property ((ce_i && en_vec[0] && com_vec[0] && frame
    && !pin_data_i[0]) |=> lcd_level_o[1:0] == 2'h2)
    else $error("common frame 1 bias wrong");

  com_rail1_a: assert property ((ce_i && en_vec[0] && com_vec[0] && frame
    && pin_data_i[0]) |=> lcd_level_o[1:0] == 2'h0)
    else $error("common frame 1 rail wrong");

  com_pin5_a: assert property ((ce_i && en_vec[5] && com_vec[5] && !frame
    && pin_data_i[5]) |=> lcd_level_o[11:10] == 2'h3)
    else $error("last common pin rail wrong");

  seg_frame0_a: assert property ((ce_i && en_vec[6] && !frame && !pin_data_i[6])
    |=> lcd_level_o[13:12] == 2'h2)
    else $error("segment frame 0 bias wrong");

  seg_bias1_a: assert property ((ce_i && en_vec[6] && frame && !pin_data_i[6])
    |=> lcd_level_o[13:12] == 2'h1)
    else $error("segment frame 1 bias wrong");

  seg_rail0_a: assert property ((ce_i && en_vec[23] && !frame && pin_data_i[23])
    |=> lcd_level_o[47:46] == 2'h0)
    else $error("segment frame 0 rail wrong");

  seg_frame1_a: assert property ((ce_i && en_vec[23] && frame && pin_data_i[23])
    |=> lcd_level_o[47:46] == 2'h3)
    else $error("segment frame 1 rail wrong");

  role_seg_a: assert property ((ce_i && en_vec[1] && !com_vec[1] && frame
    && !pin_data_i[1]) |=> lcd_level_o[3:2] == 2'h1)
    else $error("role bit segment level wrong");

  role_com_a: assert property ((ce_i && en_vec[1] && com_vec[1] && frame
    && !pin_data_i[1]) |=> lcd_level_o[3:2] == 2'h2)
    else $error("role bit common level wrong");

  bias_write_a: assert property ((ce_i && req && wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == `SLCD_OFF_MAIN) |=> bias_current_o == $past(wb_dat_i[6:5]))
    else $error("bias current field not written");

  frame_write_a: assert property ((ce_i && req && wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == `SLCD_OFF_MAIN) |=> frame == $past(wb_dat_i[`SLCD_FRAME_BIT]))
    else $error("frame bit not written");

  seg_high_mask_a: assert property ((ce_i && req && wb_ack_o && wb_we_i
    && wb_adr_i == `SLCD_OFF_SEG_HIGH) |=> state.regs[4][7:2] == '0)
    else $error("unused upper segment bits stored");

  // Reset must be watched while it is high, so no disable here
  reset_zero_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
    |=> (lcd_active_o == '0 && lcd_level_o == '0 && bias_current_o == 2'h0 && !wb_ack_o))
    else $error("state not cleared by reset");

  high_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == `SLCD_OFF_SEG_HIGH)
    |-> wb_dat_o[31:2] == '0)
    else $error("upper segment bits not zero");

  read_data_a: assert property ((ce_i && req && !wb_ack_o && !wb_we_i
    && wb_adr_i == `SLCD_OFF_MAIN) |=> wb_dat_o == {24'h00_0000, $past(state.regs[0])})
    else $error("main register read data wrong");

  unmapped_read_a: assert property ((ce_i && req && !wb_ack_o && reg_index(wb_adr_i) < 0)
    |=> wb_dat_o == '0)
    else $error("unmapped read not zero");

  unmapped_write_a: assert property ((ce_i && req && wb_ack_o && wb_we_i
    && reg_index(wb_adr_i) < 0) |=> $stable(state.regs))
    else $error("unmapped write changed a register");

  sel_ignore_a: assert property ((ce_i && req && wb_ack_o && wb_we_i && !wb_sel_i[0])
    |=> $stable(state.regs))
    else $error("write without byte lane changed a register");

  dat_hold_a: assert property (!(ce_i && req && !wb_ack_o)
    |=> $stable(wb_dat_o))
    else $error("read data moved without a request");

  ack_reply_a: assert property ((ce_i && req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  freeze_ce_a: assert property (!ce_i |=> $stable(state))
    else $error("state moved with clock enable low");

  // One check per pin: a pin outside LCD duty is held at ground
  generate
    for (g = 0; g < `SLCD_NUM_PINS; g++) begin : gen_pin_chk
      pin_off_vss_a: assert property ((ce_i && !en_vec[g])
        |=> lcd_level_o[2*g+1:2*g] == 2'h0)
        else $error("disabled pin not at ground");
    end
  endgenerate

  frame_toggle_c: cover property (en_vec[0] && frame ##1 en_vec[0] && !frame);
  seg_drive_c: cover property (en_vec[23] && master);
  write_main_c: cover property (req && wb_ack_o && wb_we_i && wb_adr_i == `SLCD_OFF_MAIN);
  seg_frame1_c: cover property (en_vec[23] && frame && pin_data_i[23]);
  freeze_c: cover property (!ce_i && master);

endmodule
`default_nettype wire

// file: design/slcd_defs.svh
// Constants for the software LCD pin driver control block.
// Assumes inclusion by its bare name from the package and the design.
`ifndef SLCD_DEFS_SVH
`define SLCD_DEFS_SVH

// ----------------------------------------
// Register byte offsets on the bus
// ----------------------------------------
`define SLCD_OFF_MAIN 8'h00
`define SLCD_OFF_ROLE 8'h04
`define SLCD_OFF_SEG_LOW 8'h08
`define SLCD_OFF_SEG_MID 8'h0C
`define SLCD_OFF_SEG_HIGH 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLCD_FRAME_BIT 7
`define SLCD_ISEL_HI 6
`define SLCD_ISEL_LO 5
`define SLCD_MASTER_BIT 4
`define SLCD_SEG_HIGH_MASK 8'h03

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define SLCD_REG_RESET 8'h00
`define SLCD_NUM_REGS 5
`define SLCD_NUM_PINS 24
`define SLCD_NUM_COM 6

`endif

// file: design/slcd_pkg.sv
// Types for the software LCD pin driver control block.
// Assumes slcd_defs.svh is on the include path.
`include "slcd_defs.svh"

package slcd_pkg;

  // ----------------------------------------
  // Drive level codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SLCD_LVL_VSS = 2'h0,
    SLCD_LVL_THIRD = 2'h1,
    SLCD_LVL_TWO_THIRD = 2'h2,
    SLCD_LVL_VDD = 2'h3
  } slcd_level_t;

  // ----------------------------------------
  // Whole state of the block
  // ----------------------------------------
  typedef struct packed {
    logic [`SLCD_NUM_REGS-1:0][7:0] regs;
    logic ack;
    logic [31:0] rdata;
    logic [`SLCD_NUM_PINS-1:0][1:0] level;
    logic [`SLCD_NUM_PINS-1:0] active;
  } slcd_state_t;

endpackage

// file: verif/slcd_panel.sv
// Passive LCD panel model: one pixel between pin 0 and pin 1.
// Assumes level codes in thirds of the supply, two bits a pin.
`timescale 1ns/1ps
`default_nettype none
module slcd_panel (
  input wire logic [47:0] level_i,
  input wire logic [23:0] active_i,
  output logic [1:0] pixel_o
);
  // Undriven electrodes drift to ground
  logic [1:0] com, seg;
  assign com = active_i[0] ? level_i[1:0] : 2'h0;
  assign seg = active_i[1] ? level_i[3:2] : 2'h0;
  assign pixel_o = (com > seg) ? com - seg : seg - com;
endmodule
`default_nettype wire

// file: verif/tb.sv
// Testbench for the LCD pin driver control block.
// Assumes the design and a panel model on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [23:0] pd = 24'h0;
  wire [31:0] rdat;
  wire ack;
  wire [47:0] lvl;
  wire [23:0] act;
  wire [1:0] bias, pix;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  slcd_ctrl slcd_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_data_i(pd), .lcd_level_o(lvl),
    .lcd_active_o(act), .bias_current_o(bias));
  slcd_panel slcd_panel_i (.level_i(lvl), .active_i(act), .pixel_o(pix));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic [1:0] lv(input logic seg, input logic fr, input logic d);
    logic [1:0] c;
    c = fr ? (d ? 2'h0 : 2'h2) : (d ? 2'h3 : 2'h1);
    return seg ? 2'h3 - c : c;
  endfunction
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 5; r++) rd(8'(r * 4), 32'h0);
    rd(8'h20, 32'h0);
    chk(act, 48'h0);
    wb(1'b1, 8'h00, 32'hEF);
    wb(1'b1, 8'h04, 32'hC2);
    pd <= 24'hFFFFFF;
    settle;
    chk(act, 48'h0);
    chk(lvl, 48'h0);
    chk(bias, 48'h3);
    rd(8'h00, 32'hEF);
    for (int f = 0; f < 2; f++) begin
      for (int d = 0; d < 2; d++) begin
        wb(1'b1, 8'h00, {24'h0, f[0], 2'h1, 5'h1F});
        pd <= {24{d[0]}};
        settle;
        chk(lvl[1:0], lv(1'b0, f[0], d[0]));
        chk(lvl[3:2], lv(1'b1, f[0], d[0]));
        chk(pix, d[0] ? 48'h3 : 48'h1);
      end
    end
    chk(bias, 48'h1);
    chk(act, 48'h3F);
    wb(1'b1, 8'h08, 32'hFF);
    wb(1'b1, 8'h0C, 32'hFF);
    wb(1'b1, 8'h10, 32'hFF);
    settle;
    chk(act, 48'hFFFFFF);
    @(posedge clk_i);
    ce <= 1'b0;
    pd <= 24'h0;
    settle;
    chk(lvl[1:0], 48'h0);
    @(posedge clk_i);
    ce <= 1'b1;
    settle;
    chk(lvl[1:0], 48'h2);
    rd(8'h10, 32'h3);
    rd(8'h04, 32'hC2);
    wb(1'b1, 8'h00, 32'h8F);
    settle;
    chk(act, 48'h0);
    chk(lvl, 48'h0);
    chk(bias, 48'h0);
    conclude;
  end
  // Whole run is under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    conclude;
  end
endmodule
`default_nettype wire
